//--- core/padc_map.svh
// Constants for the converter output port: widths, codes and pipeline figures.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PADC_MAP_SVH
`define PADC_MAP_SVH

// ****************************************
// Word layout and codes
// ****************************************
`define PADC_WORD_W      15
`define PADC_SIGN_BIT    14
`define PADC_IN_W        16
`define PADC_POS_FS      15'h3FFF
`define PADC_NEG_FS      15'h4000

// ****************************************
// Pipeline and buffering
// ****************************************
`define PADC_LATENCY     3
`define PADC_SYNC_STAGES 3
`define PADC_FIFO_DEPTH  8

`endif

//--- core/padc_pkg.sv
// Types shared by the converter output port and its buffer.
// Assumes the constant header is on the include path.
`include "padc_map.svh"

package padc_pkg;

    typedef struct packed {
        logic                     ovr;
        logic [`PADC_WORD_W-1:0]  word;
    } padc_sample_t;

    localparam int PADC_SAMPLE_W = $bits(padc_sample_t);

endpackage : padc_pkg

//--- core/padc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an asynchronous active-high reset.
module padc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

endmodule // padc_fifo

//--- core/padc_out_port.sv
// Output side of a pipelined sampling converter: sample, code, delay, strobe.
// Assumes the conversion clock arrives unsynchronised and far slower than mclk_i.
`include "padc_map.svh"

module padc_out_port
    import padc_pkg::*;
#(
    parameter int IN_W       = `PADC_IN_W,
    parameter int FIFO_DEPTH = `PADC_FIFO_DEPTH
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    input  wire logic                   conv_clock_pos_i,
    input  wire logic                   conv_clock_neg_i,
    input  wire logic signed [IN_W-1:0] analog_in_pos_i,
    input  wire logic signed [IN_W-1:0] analog_in_neg_i,
    output logic [`PADC_WORD_W-1:0]     sample_word_bits_o,
    output logic                        overrange_flag_o,
    output logic                        sample_valid_strobe_o,
    output logic                        sample_dropped_o
);

    // ****************************************
    // Conversion clock sampling
    // ****************************************
    logic [`PADC_SYNC_STAGES-1:0] conv_sync;
    logic                         conv_level;
    logic                         conv_rise;
    logic                         conv_fall;
    logic                         conv_agree;

    // Differential receiver: high when the positive leg leads
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            conv_sync <= '0;
        end else begin
            conv_sync <= {conv_sync[`PADC_SYNC_STAGES-2:0], conv_clock_pos_i & ~conv_clock_neg_i};
        end
    end

    // Second and third stage must agree, which filters a single-cycle glitch
    assign conv_agree = (conv_sync[1] == conv_sync[2]);
    assign conv_rise  = conv_agree && conv_sync[1] && !conv_level;
    assign conv_fall  = conv_agree && !conv_sync[1] && conv_level;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            conv_level <= 1'b0;
        end else if (conv_agree) begin
            conv_level <= conv_sync[1];
        end
    end

    // ****************************************
    // Quantiser
    // ****************************************
    function automatic padc_sample_t quantize(input logic signed [IN_W-1:0] pos,
                                              input logic signed [IN_W-1:0] neg);
        logic signed [IN_W:0] diff;
        logic signed [IN_W:0] hi;
        logic signed [IN_W:0] lo;
        padc_sample_t         s;
        diff = (IN_W+1)'(pos) - (IN_W+1)'(neg);
        hi   = (IN_W+1)'($signed(`PADC_POS_FS));
        lo   = (IN_W+1)'($signed(`PADC_NEG_FS));
        if (diff > hi) begin
            s.ovr  = 1'b1;
            s.word = `PADC_POS_FS;
        end else if (diff < lo) begin
            s.ovr  = 1'b1;
            s.word = `PADC_NEG_FS;
        end else begin
            s.ovr  = 1'b0;
            s.word = diff[`PADC_WORD_W-1:0];
        end
        return s;
    endfunction

    // Inputs are taken as settled at the detected edge; the analog path has no flops
    padc_sample_t cap;
    logic         cap_valid;
    logic         fifo_in_ready;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cap <= '0;
        end else if (conv_rise) begin
            cap <= quantize(analog_in_pos_i, analog_in_neg_i);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_valid <= 1'b0;
        end else if (conv_rise) begin
            cap_valid <= 1'b1;
        end else if (fifo_in_ready) begin
            cap_valid <= 1'b0;
        end
    end

    // A held word overwritten by the next edge is lost; flag it for one cycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_dropped_o <= 1'b0;
        end else begin
            sample_dropped_o <= conv_rise && cap_valid && !fifo_in_ready;
        end
    end

    // ****************************************
    // Buffer and output pipeline
    // ****************************************
    padc_sample_t fifo_out;
    logic         fifo_out_valid;
    logic         pend_take;
    padc_sample_t pend;
    logic         pend_valid;
    padc_sample_t pipe [`PADC_LATENCY];

    padc_fifo #(
        .WIDTH (PADC_SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (cap_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (cap),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pend_take),
        .out_data_o  (fifo_out)
    );

    // Pending slot stalls the buffer until the pipeline consumes it
    assign pend_take = !pend_valid || conv_rise;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pend       <= '0;
            pend_valid <= 1'b0;
        end else if (pend_take) begin
            pend       <= fifo_out;
            pend_valid <= fifo_out_valid;
        end
    end

    // Word and flag move together so the flag qualifies its own sample
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < `PADC_LATENCY; i++) begin
                pipe[i] <= '0;
            end
        end else if (conv_rise) begin
            pipe[0] <= pend_valid ? pend : pipe[0];
            for (int i = 1; i < `PADC_LATENCY; i++) begin
                pipe[i] <= pipe[i-1];
            end
        end
    end

    assign sample_word_bits_o = pipe[`PADC_LATENCY-1].word;
    assign overrange_flag_o   = pipe[`PADC_LATENCY-1].ovr;

    // Strobe is the inverted clock, so its rise sits mid-period to the data change
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_valid_strobe_o <= 1'b0;
        end else begin
            sample_valid_strobe_o <= conv_agree ? !conv_sync[1] : !conv_level;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    logic signed [IN_W:0] past_diff;
    assign past_diff = (IN_W+1)'(analog_in_pos_i) - (IN_W+1)'(analog_in_neg_i);

    sequence s_rise;
        conv_rise;
    endsequence

    sequence s_out_step;
        conv_rise ##1 (sample_word_bits_o == $past(pipe[`PADC_LATENCY-2].word));
    endsequence

    property p_sample_on_rise;
        @(posedge mclk_i) disable iff (rst_i)
        s_rise |=> (cap == $past(quantize(analog_in_pos_i, analog_in_neg_i)));
    endproperty
    a_sample_on_rise: assert property (p_sample_on_rise)
        else $error("capture does not match input at conversion edge");

    property p_out_moves_on_rise;
        @(posedge mclk_i) disable iff (rst_i)
        $changed(sample_word_bits_o) |-> $past(conv_rise);
    endproperty
    a_out_moves_on_rise: assert property (p_out_moves_on_rise)
        else $error("output word changed away from a conversion edge");

    property p_out_step;
        @(posedge mclk_i) disable iff (rst_i)
        s_rise |-> s_out_step;
    endproperty
    a_out_step: assert property (p_out_step)
        else $error("output stage did not take previous stage");

    property p_strobe_after_fall;
        @(posedge mclk_i) disable iff (rst_i)
        conv_fall |=> sample_valid_strobe_o [*2];
    endproperty
    a_strobe_after_fall: assert property (p_strobe_after_fall)
        else $error("strobe not high after conversion clock fall");

    property p_strobe_low_after_rise;
        @(posedge mclk_i) disable iff (rst_i)
        conv_rise |=> !sample_valid_strobe_o;
    endproperty
    a_strobe_low_after_rise: assert property (p_strobe_low_after_rise)
        else $error("strobe not low after conversion clock rise");

    property p_full_scale_clip;
        @(posedge mclk_i) disable iff (rst_i)
        (conv_rise && past_diff > (IN_W+1)'($signed(`PADC_POS_FS)))
            |=> (cap.word == `PADC_POS_FS) && cap.ovr;
    endproperty
    a_full_scale_clip: assert property (p_full_scale_clip)
        else $error("positive overrange not clipped and flagged");

    property p_in_range_clear;
        @(posedge mclk_i) disable iff (rst_i)
        (conv_rise && past_diff <= (IN_W+1)'($signed(`PADC_POS_FS))
                   && past_diff >= (IN_W+1)'($signed(`PADC_NEG_FS))) |=> !cap.ovr;
    endproperty
    a_in_range_clear: assert property (p_in_range_clear)
        else $error("overrange flagged for in-range input");

    property p_flag_timing;
        @(posedge mclk_i) disable iff (rst_i)
        $changed(overrange_flag_o) |-> $past(conv_rise);
    endproperty
    a_flag_timing: assert property (p_flag_timing)
        else $error("overrange flag moved away from a conversion edge");

    property p_sign_bit;
        @(posedge mclk_i) disable iff (rst_i)
        s_rise |=> (cap.word[`PADC_SIGN_BIT] == $past(past_diff[IN_W]));
    endproperty
    a_sign_bit: assert property (p_sign_bit)
        else $error("sign bit disagrees with input polarity");

endmodule // padc_out_port

//--- testbench/padc_tb_latch.sv
// Capture latch standing at the far side of the converter output port.
// Assumes the strobe is a clean level that rises once per sample.
`include "padc_map.svh"

module padc_tb_latch (
    input  wire logic                    sample_valid_strobe_i,
    input  wire logic [`PADC_WORD_W-1:0] sample_word_bits_i,
    input  wire logic                    overrange_flag_i,
    output logic [`PADC_WORD_W-1:0]      cap_word_o,
    output logic                         cap_ovr_o,
    output int                           cap_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Capture on the strobe as a clock
    // ****************************************
    int cnt = 0;
    assign cap_cnt_o = cnt;
    always @(posedge sample_valid_strobe_i) begin
        cap_word_o <= sample_word_bits_i;
        cap_ovr_o  <= overrange_flag_i;
        cnt        <= cnt + 1;
    end
endmodule // padc_tb_latch

//--- testbench/testbench.sv
// Self-checking bench for the converter output port and its buffer.
// Assumes the conversion clock is much slower than mclk_i.
`include "padc_map.svh"

module testbench;
    import padc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      mclk_i, rst_i, conv_clk = 1'b0, conv_run, drop_seen;
    logic signed [15:0]        a_pos, a_neg;
    logic [`PADC_WORD_W-1:0]   word, cap_word;
    logic                      ovr, stb, dropped, cap_ovr;
    logic [15:0]               exp_q[$];
    int                        cap_cnt, n_fall, n_fail, compares, t;
    logic signed [15:0] cp [8] = '{16'h3FFF, 16'h4000, 16'h0000, 16'h0000,
                                   16'h0001, 16'h0000, 16'h3E80, 16'h0001};
    logic signed [15:0] cn [8] = '{16'h0000, 16'h0000, 16'h4000, 16'h4001,
                                   16'h0001, 16'h0001, 16'hC180, 16'h0000};

    padc_out_port dut (.mclk_i(mclk_i), .rst_i(rst_i), .conv_clock_pos_i(conv_clk),
        .conv_clock_neg_i(~conv_clk), .analog_in_pos_i(a_pos), .analog_in_neg_i(a_neg),
        .sample_word_bits_o(word), .overrange_flag_o(ovr),
        .sample_valid_strobe_o(stb), .sample_dropped_o(dropped));
    padc_tb_latch latch (.sample_valid_strobe_i(stb), .sample_word_bits_i(word),
        .overrange_flag_i(ovr), .cap_word_o(cap_word), .cap_ovr_o(cap_ovr),
        .cap_cnt_o(cap_cnt));

    // ****************************************
    // Clocks, reference coding, check helpers
    // ****************************************
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    // Even duty and a period of eight mclk_i cycles, so sync delay is the same at every edge
    initial begin
        wait (conv_run);
        #13;
        while (conv_run) begin
            #160 conv_clk = 1'b1;
            #160 conv_clk = 1'b0;
        end
    end

    function automatic logic [15:0] code(input logic signed [15:0] p, input logic signed [15:0] n);
        int d;
        d = int'(p) - int'(n);
        if (d > 16383) return 16'hBFFF;
        if (d < -16384) return 16'hC000;
        return {1'b0, d[14:0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************
    // Stream: expectations, captures, strobe
    // ****************************************
    always @(posedge conv_clk) exp_q.push_back(code(a_pos, a_neg));
    always @(cap_cnt) if (n_fall >= 4) check({cap_ovr, cap_word}, exp_q[n_fall-4]);
    always @(posedge dropped) drop_seen = 1'b1;
    always @(negedge conv_clk) begin
        n_fall++;
        // New inputs right after the fall, so they stand well before the next sampling rise
        @(negedge mclk_i);
        if (n_fall < 8) begin
            a_pos = cp[n_fall];
            a_neg = cn[n_fall];
        end else begin
            a_pos = 16'($urandom_range(32000) - 16000);
            a_neg = 16'($urandom_range(32000) - 16000);
        end
        t = 0;
        while (stb !== 1'b1 && t < 8) begin
            @(negedge mclk_i);
            t++;
        end
        check(16'(t < 8), 16'h0001);
    end

    initial begin
        #200000;
        n_fail++;
        complete_run();
    end

    initial begin
        rst_i = 1'b1; conv_run = 1'b0; drop_seen = 1'b0; a_pos = cp[0]; a_neg = cn[0];
        n_fail = 0; compares = 0; n_fall = 0;
        void'($urandom(28187));
        repeat (16) @(posedge mclk_i);
        // Outputs in reset, then two edges after release with the clock idle low
        @(negedge mclk_i);
        check({ovr, word}, 16'h0000);
        check(16'(stb), 16'h0000);
        check(16'(dropped), 16'h0000);
        rst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        check({ovr, word}, 16'h0000);
        check(16'(stb), 16'h0001);
        $display("reset test done, n_fail %0d", n_fail);
        conv_run = 1'b1;
        wait (n_fall == 48);
        conv_run = 1'b0;
        repeat (20) @(posedge mclk_i);
        check(16'(drop_seen), 16'h0000);
        check(16'(cap_cnt > 40), 16'h0001);
        $display("stream test done, n_fail %0d", n_fail);
        complete_run();
    end
endmodule // testbench
